// ===== verilog/stq_pkg.sv
package stq_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int CH_N      = 16;            // Probed channels
	localparam int TW        = 32;            // Elapsed-time counter width
	localparam int CLK_NS    = 10;            // Sample clock period
	// Smallest qualification time, rounded up to whole cycles
	localparam int MIN_QUAL_NS  = 2;
	localparam int MIN_QUAL_CYC = (MIN_QUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [TW-1:0] TMAX = {TW{1'b1}};
	localparam logic [TW-1:0] T_RST = 32'h0000_0000;
	localparam logic [15:0]   CNT16_RST = 16'h0000;

	// ------------------------------------------------------------
	// Per-channel level and combining function
	// ------------------------------------------------------------
	typedef enum logic [1:0] {LV_X, LV_HI, LV_LO} stq_lvl_e;
	typedef enum logic [1:0] {FN_AND, FN_NAND, FN_OR, FN_NOR} stq_fn_e;
	typedef enum logic [2:0] {
		Q_GT, Q_LT, Q_TIMEOUT, Q_INSIDE, Q_OUTSIDE
	} stq_qual_e;

	// One pattern: per-channel levels and combining function
	typedef struct packed {
		stq_lvl_e [CH_N-1:0] lvl;
		stq_fn_e             fn;
	} stq_pat_s;

	// Time qualification setup
	typedef struct packed {
		stq_qual_e       qual;
		logic [TW-1:0]   lim_lo;   // Limit, or lower limit in range mode
		logic [TW-1:0]   lim_hi;   // Upper limit in range mode
	} stq_tq_s;

	// Acquisition control
	typedef struct packed {
		logic        auto_mode;
		logic        single;
		logic [15:0] pre_len;     // Pretrigger samples
		logic [15:0] post_len;    // Posttrigger samples
		logic [15:0] dly_post_len;// Posttrigger samples of delayed record
		logic        dly_en;      // Delayed trigger in use
		logic [TW-1:0] auto_wait; // Auto-mode wait in cycles
	} stq_acq_s;

	// Status lamps
	typedef struct packed {
		logic trigd;
		logic ready;
		logic armed;
	} stq_stat_s;

endpackage

// ===== verilog/stq_trigger.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE_01] Minimum qualification is one cycle, fires promptly
// [RULE_02] End pattern considered only after start
// [RULE_03] Start pattern true starts elapsed timer
// [RULE_04] Watch end pattern while timer runs
// [RULE_05] Time-out triggers when timer reaches limit
// [RULE_06] Time-out: early end pattern rearms
// [RULE_07] Other qualifiers trigger at end pattern
// [RULE_08] Greater-than: gap must exceed limit
// [RULE_09] Less-than: gap must be below limit
// [RULE_10] Range: lower/upper limits, inside or outside
// [RULE_11] Force starts acquisition without trigger
// [RULE_12] Force works in holdoff, not when stopped
// [RULE_13] Single-shot: one trigger, stop, await run
// [RULE_14] Triggered lamp while filling posttrigger
// [RULE_15] Ready lamp while awaiting a trigger
// [RULE_16] Armed lamp while filling pretrigger
// [RULE_17] Delayed wait shows triggered plus ready
// [RULE_18] Midpoint command sets threshold halfway
// [RULE_19] Patterns use per-channel match, selectable function
// [RULE_20] All don't-care pattern never matches
// [RULE_21] Normal mode acquires only on trigger
// [RULE_22] Auto mode forces after wait elapses
// [RULE_23] Elapsed counter saturates, never wraps
// [RULE_24] Finished sequence clears timer, rearms
module stq_trigger
	import stq_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic [CH_N-1:0] probe,              // Probed inputs
	input  wire stq_pat_s        start_pat,          // Start pattern
	input  wire stq_pat_s        end_pat,            // End pattern
	input  wire stq_tq_s         tq,                 // Time qualification
	input  wire stq_acq_s        acq,                // Acquisition setup
	input  wire logic            run_cmd,            // Run pulse
	input  wire logic            stop_cmd,           // Stop pulse
	input  wire logic            force_trig,         // Force pulse
	input  wire logic            dly_event,          // Delayed trigger event
	input  wire logic            midpoint_level_set, // Midpoint command pulse
	input  wire logic [11:0]     peak_hi,            // Observed upper peak
	input  wire logic [11:0]     peak_lo,            // Observed lower peak
	output logic                 trig_pulse,         // Trigger point strobe
	output logic                 acq_running,        // Acquisition system on
	output stq_stat_s            status,             // Lamps
	output logic [11:0]          threshold           // Trigger threshold
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rs1_q;   // First stage, read only by second
	logic rs2_q;   // Internal reset, active low

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end
		else
		begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end

	// ------------------------------------------------------------
	// Pattern evaluation
	// ------------------------------------------------------------
	// Shared by start and end; an all don't-care setup never matches
	function automatic logic pat_true(input stq_pat_s p, input logic [CH_N-1:0] x);
		logic any_and;
		logic any_or;
		logic used;
		logic r;
		any_and = 1'b1;
		any_or  = 1'b0;
		used    = 1'b0;
		for (int i = 0; i < CH_N; i++)
		begin
			if (p.lvl[i] == LV_HI || p.lvl[i] == LV_LO)
			begin
				used    = 1'b1;
				any_and = any_and & ((p.lvl[i] == LV_HI) == x[i]);   // [RULE_19]
				any_or  = any_or  | ((p.lvl[i] == LV_HI) == x[i]);
			end
		end
		case (p.fn)
			FN_AND:  r = any_and;
			FN_NAND: r = ~any_and;
			FN_OR:   r = any_or;
			FN_NOR:  r = ~any_or;
			default: r = 1'b0;
		endcase
		return used & r;   // [RULE_20]
	endfunction

	logic start_hit;   // Start pattern true now
	logic end_hit;     // End pattern true now

	always_comb
	begin
		start_hit = pat_true(start_pat, probe);
		end_hit   = pat_true(end_pat, probe);
	end

	// ------------------------------------------------------------
	// Sequence qualifier
	// ------------------------------------------------------------
	typedef enum logic {SQ_IDLE, SQ_TIMING} stq_sq_e;
	stq_sq_e       sq_q, sq_d;      // Sequence state
	logic [TW-1:0] gap_q, gap_d;    // Elapsed cycles since start
	logic          seq_hit;         // Qualified sequence trigger
	logic          listen;          // Trigger system accepting events
	logic [TW-1:0] lim_eff;         // Limit floored at one cycle

	// Sequence watcher: runs only while a trigger can be taken
	always_comb
	begin
		sq_d    = sq_q;
		gap_d   = gap_q;
		seq_hit = 1'b0;
		// For greater-than and time-out, a limit below the hardware minimum acts as the minimum
		lim_eff = (tq.lim_lo < TW'(MIN_QUAL_CYC)) ? TW'(MIN_QUAL_CYC) : tq.lim_lo;   // [RULE_01]
		if (!listen)
		begin
			sq_d  = SQ_IDLE;
			gap_d = T_RST;
		end
		else
		begin
			case (sq_q)
				SQ_IDLE:
				begin
					if (start_hit)   // [RULE_02]
					begin
						sq_d  = SQ_TIMING;   // [RULE_03]
						gap_d = T_RST;
					end
				end
				SQ_TIMING:
				begin
					// Saturate so very long gaps still compare as long
					gap_d = (gap_q == TMAX) ? TMAX : gap_q + 1'b1;   // [RULE_23]
					if (tq.qual == Q_TIMEOUT)
					begin
						if (end_hit)
							sq_d = SQ_IDLE;   // [RULE_06]
						else if (gap_d >= lim_eff)
						begin
							seq_hit = 1'b1;   // [RULE_05]
							sq_d    = SQ_IDLE;
						end
					end
					else if (end_hit)   // [RULE_04]
					begin
						sq_d = SQ_IDLE;   // [RULE_24]
						case (tq.qual)   // [RULE_07]
							Q_GT:      seq_hit = (gap_d > lim_eff);   // [RULE_08]
							Q_LT:      seq_hit = (gap_d < tq.lim_lo);   // [RULE_09]
							Q_INSIDE:  seq_hit = (gap_d >= tq.lim_lo) && (gap_d <= tq.lim_hi);   // [RULE_10]
							Q_OUTSIDE: seq_hit = (gap_d < tq.lim_lo) || (gap_d > tq.lim_hi);   // [RULE_10]
							default:   seq_hit = 1'b0;
						endcase
					end
					if (sq_d == SQ_IDLE)
						gap_d = T_RST;   // [RULE_24]
				end
				default:
				begin
					sq_d  = SQ_IDLE;
					gap_d = T_RST;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rs2_q)
	begin
		if (!rs2_q)
		begin
			sq_q  <= SQ_IDLE;
			gap_q <= T_RST;
		end
		else
		begin
			sq_q  <= sq_d;
			gap_q <= gap_d;
		end
	end

	// ------------------------------------------------------------
	// Acquisition state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {AQ_STOP, AQ_PRE, AQ_READY, AQ_POST, AQ_DLY_WAIT, AQ_DLY_POST}
		stq_aq_e;
	stq_aq_e       aq_q, aq_d;       // Acquisition state
	logic [15:0]   cnt_q, cnt_d;     // Sample count in current phase
	logic [TW-1:0] auto_q, auto_d;   // Auto-mode wait counter
	logic          trig_d;           // Trigger strobe next value
	logic          run_d;            // Running flag next value
	stq_stat_s     stat_d;           // Lamps next value

	always_comb
	begin
		aq_d   = aq_q;
		cnt_d  = cnt_q;
		auto_d = auto_q;
		trig_d = 1'b0;
		listen = (aq_q == AQ_READY);   // [RULE_21]
		case (aq_q)
			AQ_STOP:
			begin
				// Force is ignored here: it never restarts a stopped system
				if (run_cmd)   // [RULE_12]
				begin
					aq_d  = AQ_PRE;
					cnt_d = CNT16_RST;
				end
			end
			AQ_PRE:
			begin
				// Pretrigger holdoff; force still breaks through
				cnt_d = cnt_q + 1'b1;
				if (force_trig)   // [RULE_12]
				begin
					aq_d   = AQ_POST;
					trig_d = 1'b1;
					cnt_d  = CNT16_RST;
				end
				else if (cnt_d >= acq.pre_len)
				begin
					aq_d   = AQ_READY;
					auto_d = T_RST;
				end
			end
			AQ_READY:
			begin
				auto_d = (auto_q == TMAX) ? TMAX : auto_q + 1'b1;
				if (seq_hit || force_trig ||   // [RULE_11]
					(acq.auto_mode && auto_d >= acq.auto_wait))   // [RULE_22]
				begin
					aq_d   = acq.dly_en ? AQ_DLY_WAIT : AQ_POST;
					trig_d = 1'b1;
					cnt_d  = CNT16_RST;
				end
			end
			AQ_DLY_WAIT:
			begin
				if (dly_event)   // [RULE_17]
				begin
					aq_d  = AQ_DLY_POST;
					cnt_d = CNT16_RST;
				end
			end
			AQ_POST, AQ_DLY_POST:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_d >= ((aq_q == AQ_POST) ? acq.post_len : acq.dly_post_len))
				begin
					// Single shot stops after one record; else rearm
					aq_d  = acq.single ? AQ_STOP : AQ_PRE;   // [RULE_13]
					cnt_d = CNT16_RST;
				end
			end
			default:
				aq_d = AQ_STOP;
		endcase
		// Stop wins over everything in flight, a same-cycle strobe too
		if (stop_cmd)
		begin
			aq_d   = AQ_STOP;
			trig_d = 1'b0;
		end
		run_d       = (aq_d != AQ_STOP);
		stat_d.armed = (aq_d == AQ_PRE);   // [RULE_16]
		stat_d.ready = (aq_d == AQ_READY) || (aq_d == AQ_DLY_WAIT);   // [RULE_15]
		stat_d.trigd = (aq_d == AQ_POST) || (aq_d == AQ_DLY_WAIT) ||   // [RULE_14]
			(aq_d == AQ_DLY_POST);   // [RULE_17]
	end

	// Midpoint of peaks, summed wide to avoid overflow
	logic [11:0] thr_d;
	logic [12:0] psum;

	always_comb
	begin
		psum  = {1'b0, peak_hi} + {1'b0, peak_lo};
		thr_d = midpoint_level_set ? psum[12:1] : threshold;   // [RULE_18]
	end

	always_ff @(posedge clk or negedge rs2_q)
	begin
		if (!rs2_q)
		begin
			aq_q        <= AQ_STOP;
			cnt_q       <= CNT16_RST;
			auto_q      <= T_RST;
			trig_pulse  <= 1'b0;
			acq_running <= 1'b0;
			status      <= '0;
			threshold   <= 12'h000;
		end
		else
		begin
			aq_q        <= aq_d;
			cnt_q       <= cnt_d;
			auto_q      <= auto_d;
			trig_pulse  <= trig_d;
			acq_running <= run_d;
			status      <= stat_d;
			threshold   <= thr_d;
		end
	end

endmodule
`default_nettype wire

// ===== verification/stq_trigger_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Port-level checks of the trigger block
// ----
module stq_trigger_asserts
	import stq_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        run_cmd,
	input  wire logic        stop_cmd,
	input  wire logic        force_trig,
	input  wire logic        midpoint_level_set,
	input  wire logic [11:0] peak_hi,
	input  wire logic [11:0] peak_lo,
	input  wire logic        trig_pulse,
	input  wire logic        acq_running,
	input  wire stq_stat_s   status,
	input  wire logic [11:0] threshold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Run taken only from the stopped state
	sequence s_run_taken;
		run_cmd && !acq_running && !stop_cmd;
	endsequence
	// Force while in holdoff or waiting, not in post-trigger fill
	sequence s_force_live;
		force_trig && acq_running && !stop_cmd && !status.trigd && (status.armed || status.ready);
	endsequence
	chk_run_arms: assert property (s_run_taken |=> acq_running && status.armed)
		else $error("run did not arm");
	chk_force_fires: assert property (s_force_live |=> trig_pulse)
		else $error("force gave no trigger");
	chk_stop_force: assert property (!acq_running && !run_cmd |=> !trig_pulse)
		else $error("trigger while stopped");
	chk_pulse_trigd: assert property (trig_pulse |-> status.trigd ##1 !trig_pulse)
		else $error("trigger strobe or lamp wrong");
	chk_armed_alone: assert property (status.armed |-> !status.ready && !status.trigd)
		else $error("armed lamp shared");
	chk_stop_wins: assert property (stop_cmd |=> !acq_running)
		else $error("stop not honoured");
	chk_trig_source: assert property (trig_pulse |-> $past(status.ready) || $past(status.armed))
		else $error("trigger from idle state");
	// Sum needs the carry bit before halving
	chk_mid_level: assert property (midpoint_level_set |=>
		threshold == 12'(({1'b0, $past(peak_hi)} + {1'b0, $past(peak_lo)}) >> 1))
		else $error("midpoint threshold wrong");
endmodule
bind stq_trigger stq_trigger_asserts i_chk (.clk(clk), .rst_n(rst_n), .run_cmd(run_cmd),
	.stop_cmd(stop_cmd), .force_trig(force_trig), .midpoint_level_set(midpoint_level_set),
	.peak_hi(peak_hi), .peak_lo(peak_lo), .trig_pulse(trig_pulse),
	.acq_running(acq_running), .status(status), .threshold(threshold));
`default_nettype wire

// ===== verification/stq_probe_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Probe source: start pattern, end pattern gap cycles later
// ----
module stq_probe_model
	import stq_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            go,    // Launch one sequence
	input  wire logic [7:0]      gap,   // Start to end, 0 = end only
	output logic      [CH_N-1:0] probe  // Driven channel levels
);
	logic [7:0] left_q = 8'h00;         // Cycles until end pattern
	initial probe = '0;
	// Idle low between sequences so neither pattern holds under AND or OR
	always @(posedge clk)
	begin
		if (go)
		begin
			probe  <= (gap == 8'h00) ? 16'h00f0 : 16'h000f;
			left_q <= gap;
		end
		else if (left_q > 8'h01)
		begin
			probe  <= '0;
			left_q <= left_q - 8'h01;
		end
		else
		begin
			probe  <= (left_q == 8'h01) ? 16'h00f0 : 16'h0000;
			left_q <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
	import stq_pkg::*;
;
	// ----
	// Stimulus and observed signals
	// ----
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [5:0]      cmd = '0;          // run stop force delayed midpoint go
	logic [7:0]      gap = '0;
	logic [CH_N-1:0] probe;
	stq_pat_s        start_pat = '0;
	stq_pat_s        end_pat = '0;
	stq_tq_s         tq = '{Q_GT, 32'h5, 32'h8};
	stq_acq_s        acq = '{1'b0, 1'b0, 16'h4, 16'h4, 16'h4, 1'b0, 32'h14};
	logic [11:0]     peak_hi = 12'hc00;
	logic [11:0]     peak_lo = 12'h401;
	logic [11:0]     threshold;
	logic            trig_pulse;
	logic            acq_running;
	stq_stat_s       status;
	int              mismatches = 0;
	int              tests_run = 0;
	int              hits;
	int              lat;
	stq_qual_e       cq [12] = '{Q_GT, Q_GT, Q_LT, Q_LT, Q_LT, Q_INSIDE, Q_INSIDE, Q_INSIDE,
		Q_OUTSIDE, Q_OUTSIDE, Q_TIMEOUT, Q_TIMEOUT};
	int              cg [12] = '{6, 5, 4, 5, 0, 5, 8, 9, 4, 8, 12, 3};
	int              ce [12] = '{1, 0, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0};
	always #5 clk = ~clk;
	stq_trigger i_dut (.clk(clk), .rst_n(rst_n), .probe(probe), .start_pat(start_pat),
		.end_pat(end_pat), .tq(tq), .acq(acq), .run_cmd(cmd[0]), .stop_cmd(cmd[1]),
		.force_trig(cmd[2]), .dly_event(cmd[3]), .midpoint_level_set(cmd[4]),
		.peak_hi(peak_hi), .peak_lo(peak_lo), .trig_pulse(trig_pulse),
		.acq_running(acq_running), .status(status), .threshold(threshold));
	stq_probe_model i_probe (.clk(clk), .go(cmd[5]), .gap(gap), .probe(probe));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle pulse; returns at the edge that takes it
	task automatic pulse(input int b);
		@(posedge clk);
		cmd <= 6'h01 << b;
		@(posedge clk);
		cmd <= '0;
	endtask
	// Count trigger strobes over n cycles, noting the first
	task automatic watch(input int n);
		hits = 0;
		lat = -1;
		for (int i = 0; i < n; i++)
		begin
			#1;
			if (trig_pulse === 1'b1)
			begin
				hits++;
				if (lat < 0)
					lat = i;
			end
			@(posedge clk);
		end
	endtask
	task automatic wait_ready;
		int i;
		i = 0;
		while (!(status.ready === 1'b1 && status.trigd === 1'b0) && i < 60)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		chk(12'(i < 60), 12'h1);
	endtask
	// One start/end sequence under qualifier q
	task automatic seq_case(input stq_qual_e q, input int g, input int e);
		@(posedge clk);
		tq.qual <= q;
		gap <= 8'(g);
		pulse(5);
		watch(40);
		chk(12'(hits), 12'(e));
		// Strobe lands one cycle after the deciding sample
		if (q == Q_TIMEOUT && e == 1)
			chk(12'(lat), 12'(tq.lim_lo + 32'h1));
		else if (e == 1)
			chk(12'(lat), 12'(g + 1));
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			start_pat.lvl[i] <= LV_HI;
			end_pat.lvl[i+4] <= LV_HI;
		end
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		pulse(0);
		#1;
		chk(12'(status), 12'h1);
		wait_ready;
		chk(12'(status), 12'h2);
		// Qualifier table: boundaries, end-first and early end
		for (int i = 0; i < 12; i++)
		begin
			seq_case(cq[i], cg[i], ce[i]);
			wait_ready;
		end
		// Smallest limit: fires one cycle after the end pattern
		@(posedge clk);
		tq.lim_lo <= 32'h0;
		seq_case(Q_GT, 2, 1);
		wait_ready;
		@(posedge clk);
		tq.lim_lo <= 32'h5;
		// End function: OR agrees with AND, NOR and NAND see idle lows
		@(posedge clk);
		end_pat.fn <= FN_OR;
		seq_case(Q_GT, 6, 1);
		wait_ready;
		@(posedge clk);
		end_pat.fn <= FN_NOR;
		seq_case(Q_GT, 6, 0);
		wait_ready;
		@(posedge clk);
		end_pat.fn <= FN_NAND;
		seq_case(Q_GT, 6, 0);
		wait_ready;
		// All don't-care start under NOR would else be always true
		@(posedge clk);
		end_pat.fn <= FN_AND;
		start_pat.fn <= FN_NOR;
		for (int i = 0; i < 4; i++)
			start_pat.lvl[i] <= LV_X;
		seq_case(Q_GT, 6, 0);
		@(posedge clk);
		start_pat.fn <= FN_AND;
		for (int i = 0; i < 4; i++)
			start_pat.lvl[i] <= LV_HI;
		wait_ready;
		pulse(2);
		watch(2);
		chk(12'(hits), 12'h1);
		// Look off the edge so the lamp has settled
		while (status.armed !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		pulse(2);
		watch(2);
		chk(12'(hits), 12'h1);
		wait_ready;
		pulse(1);
		pulse(2);
		watch(10);
		chk(12'(hits), 12'h0);
		chk(12'(acq_running), 12'h0);
		// Single shot stops after one capture
		acq.single <= 1'b1;
		pulse(0);
		wait_ready;
		seq_case(Q_GT, 6, 1);
		chk(12'(acq_running), 12'h0);
		acq.single <= 1'b0;
		acq.dly_en <= 1'b1;
		pulse(0);
		wait_ready;
		pulse(2);
		#1;
		chk(12'(status), 12'h6);
		pulse(3);
		#1;
		chk(12'(status), 12'h4);
		pulse(1);
		acq.dly_en <= 1'b0;
		acq.auto_mode <= 1'b1;
		pulse(0);
		watch(60);
		chk(12'(hits > 0), 12'h1);
		pulse(4);
		#1;
		chk(threshold, 12'h800);
		final_report;
	end
	// Whole run is under a thousand cycles
	initial
	begin
		#200000;
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire
